// ==== src/pmpl_pkg.sv ====
package pmpl_pkg;
	// System clock and the two MII clock rates
	localparam int SYS_HZ = 100_000_000;
	localparam int MII_FAST_HZ = 25_000_000;
	localparam int MII_SLOW_HZ = 2_500_000;
	localparam logic [4:0] HALF_FAST = 5'(SYS_HZ / (2 * MII_FAST_HZ));
	localparam logic [4:0] HALF_SLOW = 5'(SYS_HZ / (2 * MII_SLOW_HZ));

	// APB register byte addresses
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_PCFG = 12'h004;
	localparam logic [11:0] ADDR_XCFG = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00c;

	// Control register fields
	localparam int CTRL_LOOP_BIT = 14;
	localparam int CTRL_SPEED_BIT = 13;
	localparam int CTRL_ANEN_BIT = 12;
	localparam int CTRL_FULL_BIT = 8;
	localparam logic [15:0] CTRL_RST = 16'h3000;

	// Port configuration fields
	localparam int PCFG_FIBER_BIT = 0;
	localparam int PCFG_LBDIS_BIT = 8;
	localparam logic [15:0] PCFG_RST = 16'h0000;

	// Crossover field at bits 9:8
	localparam int XCFG_LSB = 8;
	localparam logic [1:0] XMODE_MDI = 2'h0;
	localparam logic [1:0] XMODE_MDIX = 2'h1;
	localparam logic [1:0] XMODE_AUTO = 2'h2;
	localparam logic [15:0] XCFG_RST = 16'h0200;

	// Status register bits
	localparam int STAT_CRS_BIT = 0;
	localparam int STAT_COL_BIT = 1;
	localparam int STAT_DV_BIT = 2;
	localparam int STAT_TLB_BIT = 3;
	localparam int STAT_OLB_BIT = 4;
	localparam int STAT_CROSS_BIT = 5;
	localparam int STAT_FAST_BIT = 6;
	localparam int STAT_FULL_BIT = 7;

	// Symbol classes from the line decoder
	localparam logic [2:0] KIND_IDLE = 3'h0;
	localparam logic [2:0] KIND_SSD = 3'h1;
	localparam logic [2:0] KIND_ESD = 3'h2;
	localparam logic [2:0] KIND_DATA = 3'h3;
	localparam logic [2:0] KIND_BAD = 3'h4;
	localparam logic [2:0] KIND_PRE = 3'h5;
	localparam logic [2:0] KIND_EOF = 3'h6;

	localparam logic [3:0] NIB_ERR = 4'he;

	// Strap capture: synchroniser depth plus one
	localparam logic [1:0] STRAP_DONE = 2'h3;
	localparam logic [6:0] SYNC_RST = 7'h40;
endpackage

// ==== src/pmpl_sync.sv ====
`timescale 1ns/100ps
module pmpl_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk, // Sampling clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [W-1:0] d, // Asynchronous inputs
	output logic [W-1:0] q // Synchronised outputs
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pmpl_sync_t;

	pmpl_sync_t s_r;
	pmpl_sync_t s_nxt;

	always_comb begin
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= {RST, RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.s2;
endmodule

// ==== src/pmpl_port.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Two-bit crossover field is writable; automatic crossover is the reset default.
// - Fiber bit is set when the media select pin is low after reset.
// - Software may write the fiber bit to one, selecting fiber operation.
// - Both MII clocks are sourced here: 25 MHz fast, 2.5 MHz slow.
// - Transmit data and controls are sampled on each transmit clock rise.
// - Data crosses the MII as 4-bit nibbles both ways.
// - Fast links hold receive valid from first preamble nibble to last nibble.
// - Slow links drop the preamble; receive valid starts at the SFD.
// - Carrier follows receive always, transmit only in half-duplex.
// - Fast links raise carrier on J/K and drop it on T/R.
// - Idle without T/R drops carrier and pulses receive error one clock.
// - Slow links raise carrier on valid preamble, drop it at end-of-frame.
// - Invalid fast symbol while carrier is up raises receive error and presents nibble 1110.
// - Transmit error makes the line send H symbols instead of data.
// - Collision only in half-duplex when transmit and receive overlap.
// - Slow half-duplex echoes transmit data unless loopback-disable is set.
// - Test loopback disables the line and returns transmit data to receive.
// - Test loopback needs loopback one, full-duplex one, autoneg zero.
module pmpl_port
	import pmpl_pkg::*;
(
	input wire logic pclk, // System clock, 100 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [pmpl_pkg::ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic media_select_pin, // Strap: high copper, low fiber
	input wire logic an_fast, // Negotiated 100 Mbps
	input wire logic an_full, // Negotiated full-duplex
	input wire logic cross_hint, // Auto crossover wants swap
	output logic mii_tx_clk, // Transmit clock to MAC
	output logic mii_rx_clk, // Receive clock to MAC
	input wire logic [3:0] mii_txd, // Transmit nibble from MAC
	input wire logic mii_tx_en, // Transmit enable from MAC
	input wire logic mii_tx_er, // Transmit error from MAC
	output logic [3:0] mii_rxd, // Receive nibble to MAC
	output logic mii_rx_dv, // Receive data valid
	output logic mii_rx_er, // Receive error
	output logic mii_crs, // Carrier sense
	output logic mii_col, // Collision
	input wire logic [2:0] line_rx_kind, // Decoded symbol class
	input wire logic [3:0] line_rx_nib, // Decoded receive nibble
	output logic [3:0] line_txd, // Nibble to encoder
	output logic line_tx_en, // Encoder transmit enable
	output logic line_tx_halt, // Encoder sends H symbols
	output logic line_disable, // Line interfaces disabled
	output logic line_fiber, // Fiber media selected
	output logic line_crossed // Pairs swapped
);
	import pmpl_pkg::*;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] pcfg;
		logic [15:0] xcfg;
		logic [4:0] div_cnt;
		logic [4:0] div_half;
		logic mii_clk;
		logic [1:0] strap_cnt;
		logic rx_crs;
		logic rx_dv;
		logic rx_er;
		logic [3:0] rxd;
		logic tx_en;
		logic tx_er;
		logic [3:0] txd;
		logic [3:0] ltxd;
		logic ltx_en;
		logic ltx_halt;
		logic crossed;
		logic [31:0] rdata;
	} pmpl_state_t;

	pmpl_state_t s_r;
	pmpl_state_t s_nxt;

	logic [6:0] sync_q;
	logic [3:0] txd_s;
	logic tx_en_s;
	logic tx_er_s;
	logic media_s;
	logic fast;
	logic full;
	logic test_lb;
	logic op_lb;
	logic [4:0] half;
	logic rise;
	logic wr_hit;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_PCFG) ||
			(a == ADDR_XCFG) || (a == ADDR_STAT);
	endfunction

	// Pins from the MAC and the strap come from outside this clock
	pmpl_sync #(
		.W(7),
		.RST(SYNC_RST)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({media_select_pin, mii_tx_er, mii_tx_en, mii_txd}),
		.q(sync_q)
	);

	assign txd_s = sync_q[3:0];
	assign tx_en_s = sync_q[4];
	assign tx_er_s = sync_q[5];
	assign media_s = sync_q[6];

	// Fiber runs only at 100 Mbps
	assign fast = s_r.pcfg[PCFG_FIBER_BIT] |
		(s_r.ctrl[CTRL_ANEN_BIT] ? an_fast : s_r.ctrl[CTRL_SPEED_BIT]);
	assign full = s_r.ctrl[CTRL_ANEN_BIT] ? an_full : s_r.ctrl[CTRL_FULL_BIT];
	assign test_lb = s_r.ctrl[CTRL_LOOP_BIT] & s_r.ctrl[CTRL_FULL_BIT] &
		~s_r.ctrl[CTRL_ANEN_BIT];
	assign op_lb = ~fast & ~full & ~s_r.pcfg[PCFG_LBDIS_BIT] &
		~test_lb;
	assign half = fast ? HALF_FAST : HALF_SLOW;
	// Both MII clocks rise together; this marks the rising edge
	assign rise = (s_r.div_cnt >= s_r.div_half - 5'h1) & ~s_r.mii_clk;
	assign wr_hit = psel & penable & pwrite;

	always_comb begin
		s_nxt = s_r;

		// Divider; a new rate is taken only at a clock edge, so a
		// speed change never cuts a phase of the MII clocks short
		if (s_r.div_cnt >= s_r.div_half - 5'h1) begin
			s_nxt.div_cnt = 5'h0;
			s_nxt.div_half = half;
			s_nxt.mii_clk = ~s_r.mii_clk;
		end else begin
			s_nxt.div_cnt = s_r.div_cnt + 5'h1;
		end

		// APB read data captured in setup so it comes from a flop
		if (psel && !penable) begin
			case (paddr)
			ADDR_CTRL: s_nxt.rdata = {16'h0000, s_r.ctrl};
			ADDR_PCFG: s_nxt.rdata = {16'h0000, s_r.pcfg};
			ADDR_XCFG: s_nxt.rdata = {16'h0000, s_r.xcfg};
			ADDR_STAT: begin
				s_nxt.rdata = 32'h0000_0000;
				s_nxt.rdata[STAT_CRS_BIT] = mii_crs;
				s_nxt.rdata[STAT_COL_BIT] = mii_col;
				s_nxt.rdata[STAT_DV_BIT] = s_r.rx_dv;
				s_nxt.rdata[STAT_TLB_BIT] = test_lb;
				s_nxt.rdata[STAT_OLB_BIT] = op_lb;
				s_nxt.rdata[STAT_CROSS_BIT] = s_r.crossed;
				s_nxt.rdata[STAT_FAST_BIT] = fast;
				s_nxt.rdata[STAT_FULL_BIT] = full;
			end
			default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		if (wr_hit && is_mapped(paddr)) begin
			case (paddr)
			ADDR_CTRL: s_nxt.ctrl = pwdata[15:0];
			ADDR_PCFG: s_nxt.pcfg = pwdata[15:0];
			ADDR_XCFG: begin
				s_nxt.xcfg = 16'h0000;
				s_nxt.xcfg[XCFG_LSB+:2] = pwdata[XCFG_LSB+:2];
			end
			default: s_nxt.xcfg = s_r.xcfg;
			endcase
		end

		// Strap is valid once the synchroniser has refilled after reset
		if (s_r.strap_cnt != STRAP_DONE) begin
			s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
			if (s_r.strap_cnt == STRAP_DONE - 2'h1 && !media_s) begin
				s_nxt.pcfg[PCFG_FIBER_BIT] = 1'b1;
			end
		end

		case (s_r.xcfg[XCFG_LSB+:2])
		XMODE_MDI: s_nxt.crossed = 1'b0;
		XMODE_MDIX: s_nxt.crossed = 1'b1;
		XMODE_AUTO: s_nxt.crossed = cross_hint;
		default: s_nxt.crossed = s_r.crossed;
		endcase

		if (rise) begin
			// MAC launched these on the previous rise; now stable
			s_nxt.txd = txd_s;
			s_nxt.tx_en = tx_en_s;
			s_nxt.tx_er = tx_er_s;

			if (test_lb) begin
				s_nxt.ltx_en = 1'b0;
				s_nxt.ltx_halt = 1'b0;
				s_nxt.ltxd = 4'h0;
			end else begin
				s_nxt.ltx_en = s_r.tx_en;
				s_nxt.ltxd = s_r.txd;
				s_nxt.ltx_halt = s_r.tx_en & s_r.tx_er;
			end

			s_nxt.rx_er = 1'b0;
			if (test_lb) begin
				s_nxt.rx_crs = s_r.tx_en;
				s_nxt.rx_dv = s_r.tx_en;
				s_nxt.rxd = s_r.txd;
				s_nxt.rx_er = s_r.tx_en & s_r.tx_er;
			end else if (op_lb && !s_r.rx_crs &&
				line_rx_kind != KIND_PRE) begin
				// Line receive takes priority over the echo
				s_nxt.rx_dv = s_r.tx_en;
				s_nxt.rxd = s_r.txd;
			end else if (fast) begin
				case (line_rx_kind)
				KIND_SSD: begin
					s_nxt.rx_crs = 1'b1;
					s_nxt.rx_dv = 1'b1;
					s_nxt.rxd = line_rx_nib;
				end
				KIND_ESD: begin
					s_nxt.rx_crs = 1'b0;
					s_nxt.rx_dv = 1'b0;
				end
				KIND_IDLE: begin
					s_nxt.rx_er = s_r.rx_crs;
					s_nxt.rx_crs = 1'b0;
					s_nxt.rx_dv = 1'b0;
				end
				KIND_DATA: begin
					s_nxt.rx_dv = s_r.rx_crs;
					s_nxt.rxd = line_rx_nib;
				end
				KIND_BAD: begin
					if (s_r.rx_crs) begin
						s_nxt.rx_er = 1'b1;
						s_nxt.rxd = NIB_ERR;
					end
				end
				default: begin
					s_nxt.rx_dv = s_r.rx_dv & s_r.rx_crs;
				end
				endcase
			end else begin
				case (line_rx_kind)
				KIND_PRE: begin
					s_nxt.rx_crs = 1'b1;
					s_nxt.rx_dv = 1'b0;
				end
				KIND_DATA: begin
					s_nxt.rx_dv = s_r.rx_crs;
					s_nxt.rxd = line_rx_nib;
				end
				KIND_EOF: begin
					s_nxt.rx_crs = 1'b0;
					s_nxt.rx_dv = 1'b0;
				end
				default: begin
					s_nxt.rx_dv = s_r.rx_dv & s_r.rx_crs;
				end
				endcase
			end
			if (!s_nxt.rx_dv && !s_nxt.rx_er) begin
				s_nxt.rxd = 4'h0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.ctrl <= CTRL_RST;
			s_r.pcfg <= PCFG_RST;
			s_r.xcfg <= XCFG_RST;
			s_r.div_half <= HALF_FAST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Zero wait states
	assign pready = 1'b1;
	assign prdata = s_r.rdata;
	assign pslverr = psel & penable & ~is_mapped(paddr);

	assign mii_tx_clk = s_r.mii_clk;
	assign mii_rx_clk = s_r.mii_clk;
	assign mii_rxd = s_r.rxd;
	assign mii_rx_dv = s_r.rx_dv;
	assign mii_rx_er = s_r.rx_er;
	// Its flops move only at the MII clock rise; a duplex change can still move it on any pclk edge
	assign mii_crs = s_r.rx_crs | (s_r.tx_en & ~full);
	assign mii_col = s_r.rx_crs & s_r.tx_en & ~full & ~test_lb;
	assign line_txd = s_r.ltxd;
	// Gated at once so entering test loopback never leaks a nibble
	assign line_tx_en = s_r.ltx_en & ~test_lb;
	assign line_tx_halt = s_r.ltx_halt & ~test_lb;
	assign line_disable = test_lb;
	assign line_fiber = s_r.pcfg[PCFG_FIBER_BIT];
	assign line_crossed = s_r.crossed;
endmodule

// ==== test/pmpl_port_chk.sv ====
`timescale 1ns/100ps
module pmpl_port_chk
	import pmpl_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic mii_tx_clk, // Transmit clock
	input wire logic mii_rx_clk, // Receive clock
	input wire logic [3:0] mii_rxd, // Receive nibble
	input wire logic mii_rx_dv, // Receive valid
	input wire logic mii_rx_er, // Receive error
	input wire logic mii_crs, // Carrier
	input wire logic mii_col, // Collision
	input wire logic line_tx_en, // Encoder enable
	input wire logic line_tx_halt, // Encoder H symbols
	input wire logic line_disable // Line off
);
	logic [5:0] hi_r;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// High time of the MII clock, in system clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hi_r <= '0;
		else
			hi_r <= mii_tx_clk ? hi_r + 6'h1 : '0;
	end
	clk_pair_a: assert property (mii_tx_clk == mii_rx_clk)
		else $error("MII clocks differ");
	clk_rate_a: assert property
		($fell(mii_tx_clk) |-> hi_r inside {6'h2, 6'h14})
		else $error("MII clock high time wrong");
	dv_sync_a: assert property ($changed(mii_rx_dv) |-> mii_rx_clk)
		else $error("Receive valid moved off the clock");
	col_crs_a: assert property (mii_col |-> mii_crs)
		else $error("Collision without carrier");
	col_loop_a: assert property (line_disable |-> !mii_col)
		else $error("Collision in test loopback");
	loop_off_a: assert property
		(line_disable |-> !line_tx_en && !line_tx_halt)
		else $error("Line driven in test loopback");
	err_nib_a: assert property
		(mii_rx_er && mii_rx_dv && !line_disable |-> mii_rxd == NIB_ERR)
		else $error("Error nibble wrong");
	er_pulse_a: assert property
		($rose(mii_rx_er) && !mii_rx_dv && !line_disable
		|-> (mii_rx_er && !mii_crs)[*4] ##1 !mii_rx_er)
		else $error("Receive error pulse length wrong");
	rx_quiet_a: assert property
		(!mii_rx_dv && !mii_rx_er |-> mii_rxd == 4'h0)
		else $error("Receive nibble not quiet");
	cover property ($rose(mii_rx_dv));
	cover property ($rose(mii_col));
	cover property ($rose(line_disable));
endmodule

// ==== test/pmpl_mac_model.sv ====
`timescale 1ns/100ps
module pmpl_mac_model (
	input wire logic mii_tx_clk, // Clock from the port
	input wire logic go, // Send one frame while high
	input wire logic bad, // Flag the frame as errored
	output logic [3:0] mii_txd, // Nibble to the port
	output logic mii_tx_en, // Frame active
	output logic mii_tx_er // Frame error
);
	logic [3:0] cnt = 4'h0;
	initial begin
		{mii_txd, mii_tx_en, mii_tx_er} = '0;
	end
	// Seven preamble nibbles, then the delimiter nibble
	always @(posedge mii_tx_clk) begin
		// A started frame always runs on to its delimiter nibble
		if ((go || cnt != 4'h0) && cnt < 4'h8) begin
			mii_txd <= (cnt == 4'h7) ? 4'hd : 4'h5;
			mii_tx_en <= 1'b1;
			mii_tx_er <= bad;
			cnt <= cnt + 4'h1;
		end else begin
			// Idle data keeps moving so stale nibbles never match
			mii_txd <= ~mii_txd;
			{mii_tx_en, mii_tx_er} <= 2'b00;
			if (!go)
				cnt <= 4'h0;
		end
	end
endmodule

// ==== test/pmpl_port_tb_top.sv ====
`timescale 1ns/100ps
module pmpl_port_tb_top;
	import pmpl_pkg::*;
	typedef struct packed {
		logic [2:0] kind;
		logic [3:0] nib;
		logic [6:0] exp;
	} pmpl_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic media_select_pin, an_fast, an_full, cross_hint, go, bad, clk_q;
	logic mii_tx_clk, mii_rx_clk, mii_tx_en, mii_tx_er, mii_rx_dv, mii_rx_er;
	logic mii_crs, mii_col, line_tx_en, line_tx_halt, line_disable;
	logic line_fiber, line_crossed;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] mii_txd, mii_rxd, line_rx_nib, line_txd;
	logic [2:0] line_rx_kind;
	int err_total, checks_done, n;
	pmpl_row_t rows [16];

	pmpl_port dut (.*);
	pmpl_mac_model mac_m (.*);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) clk_q <= mii_rx_clk;

	task end_sim;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task bound(input int k);
		if (k >= 500) begin
			err_total++;
			end_sim();
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 500);
		bound(n);
		rd = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		#1;
	endtask
	task rise;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (!(mii_rx_clk === 1'b1 && clk_q === 1'b0) && n < 500);
		bound(n);
	endtask
	// Each symbol's outcome is read one MII clock after it is offered
	task run(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			rise();
			@(posedge pclk);
			{line_rx_kind, line_rx_nib} <= {rows[i].kind, rows[i].nib};
			#1;
			if (i > lo)
				chk(32'({mii_rx_dv, mii_rx_er, mii_crs,
					mii_rx_dv ? mii_rxd : 4'h0}), 32'(rows[i-1].exp));
		end
		rise();
		chk(32'({mii_rx_dv, mii_rx_er, mii_crs,
			mii_rx_dv ? mii_rxd : 4'h0}), 32'(rows[hi].exp));
	endtask
	task mac(input logic b, input logic [2:0] k, input logic [12:0] x);
		@(posedge pclk);
		{go, bad, line_rx_kind, line_rx_nib} <= {1'b1, b, k, 4'h3};
		repeat (5) rise();
		@(posedge pclk);
		#1;
		chk(32'({line_tx_en, line_tx_halt, line_tx_en ? line_txd : 4'h0,
			mii_crs, mii_col, mii_rx_dv, mii_rx_dv ? mii_rxd : 4'h0}), 32'(x));
		@(posedge pclk);
		go <= 1'b0;
		// Line goes idle only once the frame has drained
		repeat (10) rise();
		@(posedge pclk);
		line_rx_kind <= KIND_IDLE;
		repeat (2) rise();
	endtask

	initial begin
		{psel, penable, pwrite, go, bad, an_full} = '0;
		{an_fast, media_select_pin, cross_hint} = 3'h7;
		{presetn, paddr, pwdata, line_rx_nib} = '0;
		line_rx_kind = KIND_IDLE;
		err_total = 0;
		checks_done = 0;
		rows = '{{KIND_IDLE, 4'h0, 7'h00}, {KIND_SSD, 4'h5, 7'h55},
			{KIND_DATA, 4'hd, 7'h5d}, {KIND_BAD, 4'h0, 7'h7e},
			{KIND_DATA, 4'h3, 7'h53}, {KIND_ESD, 4'h0, 7'h00},
			{KIND_SSD, 4'h5, 7'h55}, {KIND_IDLE, 4'h0, 7'h20},
			{KIND_IDLE, 4'h0, 7'h00}, {KIND_IDLE, 4'h0, 7'h00},
			{KIND_PRE, 4'h0, 7'h10}, {KIND_PRE, 4'h0, 7'h10},
			{KIND_DATA, 4'h5, 7'h55}, {KIND_DATA, 4'hd, 7'h5d},
			{KIND_EOF, 4'h0, 7'h00}, {KIND_IDLE, 4'h0, 7'h00}};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, '0);
		chk(rd, 32'(CTRL_RST));
		apb(1'b0, ADDR_XCFG, '0);
		chk(rd, 32'(XCFG_RST));
		apb(1'b0, 12'h010, '0);
		chk({rd[30:0], e}, 32'h1);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, ADDR_XCFG, 32'(m) << 8);
			apb(1'b0, ADDR_XCFG, '0);
			chk({rd[30:0], line_crossed}, (32'(m) << 9) | 32'(m != 0));
		end
		apb(1'b1, ADDR_XCFG, 32'(XCFG_RST));
		run(0, 9);
		@(posedge pclk);
		an_fast <= 1'b0;
		repeat (2) rise();
		run(10, 15);
		mac(1'b0, KIND_IDLE, {2'b10, 4'h5, 3'b101, 4'h5});
		apb(1'b1, ADDR_PCFG, 32'h0000_0100);
		mac(1'b0, KIND_IDLE, {2'b10, 4'h5, 3'b100, 4'h0});
		mac(1'b1, KIND_IDLE, {2'b11, 4'h5, 3'b100, 4'h0});
		@(posedge pclk);
		an_fast <= 1'b1;
		mac(1'b0, KIND_SSD, {2'b10, 4'h5, 3'b111, 4'h3});
		@(posedge pclk);
		an_full <= 1'b1;
		mac(1'b0, KIND_SSD, {2'b10, 4'h5, 3'b101, 4'h3});
		mac(1'b0, KIND_IDLE, {2'b10, 4'h5, 3'b000, 4'h0});
		apb(1'b1, ADDR_CTRL, 32'h0000_7100);
		chk(32'(line_disable), 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0000_6000);
		chk(32'(line_disable), 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0000_6100);
		chk(32'(line_disable), 32'h1);
		apb(1'b0, ADDR_STAT, '0);
		chk(rd, 32'h0000_00e8);
		mac(1'b0, KIND_IDLE, {2'b00, 4'h0, 3'b101, 4'h5});
		apb(1'b1, ADDR_PCFG, 32'h0000_0001);
		chk(32'(line_fiber), 32'h1);
		@(posedge pclk);
		{presetn, media_select_pin} <= 2'b00;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, ADDR_PCFG, '0);
		chk({rd[30:0], line_fiber}, 32'h3);
		end_sim();
	end
endmodule

bind pmpl_port pmpl_port_chk u_chk (.*);
